/* File: design/uswfc_ctrl.sv */
// Software flow control, special character and sleep controller.
`timescale 1ns/1ps
`include "uswfc_map.svh"
module uswfc_ctrl
  import uswfc_pkg::*;
#(
  parameter logic [30:0] IDLE_CYCLES = 31'(`USWFC_IDLE_CYCLES)
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Flow character writes.
  input wire logic char_wr_en,
  input wire logic [1:0] char_wr_sel,
  input wire logic [7:0] char_wr_data,
  // Configuration.
  input wire logic rx_flow_en,
  input wire logic rx_flow_double,
  input wire logic tx_auto_en,
  input wire logic tx_auto_double,
  input wire logic special_char_en,
  input wire logic [1:0] word_len_sel,
  input wire logic pause_int_en,
  input wire logic sleep_en,
  input wire logic [15:0] divisor,
  input wire logic [1:0] trig_table,
  input wire logic [1:0] trig_sel,
  input wire logic [6:0] trig_level,
  input wire logic [6:0] lower_level,
  input wire logic [6:0] hysteresis,
  // Receiver side.
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic [6:0] rx_fifo_count,
  input wire logic rxd_in,
  output logic rx_fifo_push,
  output logic [7:0] rx_fifo_data,
  // Transmitter side.
  input wire logic tx_busy,
  input wire logic tx_char_done,
  input wire logic char_time_tick,
  input wire logic flow_tx_ack,
  input wire logic thr_write,
  output logic tx_halt,
  output logic flow_tx_req,
  output logic [7:0] flow_tx_data,
  // Interrupt sources and reads.
  input wire logic other_int_pending,
  input wire logic [3:0] modem_status_delta,
  input wire logic isr_read,
  output logic flow_flag,
  output logic wake_int,
  output logic irq,
  // Power pins.
  input wire logic charge_pump_autosleep_pin,
  input wire logic isolate_pin,
  output logic osc_run,
  output logic charge_pump_on,
  output logic host_isolate
);
  uswfc_state_type st_reg;
  uswfc_state_type st_next;
  logic [3:0] hit;

  uswfc_char_match u_match (
    .word_len_sel(word_len_sel),
    .rx_char(rx_char_data),
    .resume_char1(st_reg.resume1),
    .resume_char2(st_reg.resume2),
    .pause_char1(st_reg.pause1),
    .pause_char2(st_reg.pause2),
    .match(hit)
  );

  // Pause threshold of the selected trigger table.
  function automatic logic [6:0] pause_level(input logic [1:0] tbl,
      input logic [1:0] sel, input logic [6:0] lvl);
    if (tbl == `USWFC_TABLE_B) begin
      case (sel)
        2'h0: pause_level = `USWFC_TB_LVL0;
        2'h1: pause_level = `USWFC_TB_LVL1;
        2'h2: pause_level = `USWFC_TB_LVL2;
        default: pause_level = `USWFC_TB_LVL3;
      endcase
    end else begin
      pause_level = lvl;
    end
  endfunction

  // Resume threshold: next lower level, or trigger minus hysteresis.
  function automatic logic [6:0] resume_level(input logic [1:0] tbl,
      input logic [1:0] sel, input logic [6:0] lvl, input logic [6:0] low,
      input logic [6:0] hys);
    if (tbl == `USWFC_TABLE_B) begin
      // Table B resumes on reaching its listed count, so the strict bound
      // sits one above it; a bound of zero would never resume.
      case (sel)
        2'h0: resume_level = `USWFC_TB_RES0 + 7'h01;
        2'h1: resume_level = `USWFC_TB_RES1 + 7'h01;
        2'h2: resume_level = `USWFC_TB_RES2 + 7'h01;
        default: resume_level = `USWFC_TB_RES3 + 7'h01;
      endcase
    end else if (tbl == `USWFC_TABLE_D) begin
      resume_level = (hys > lvl) ? 7'h00 : 7'(lvl - hys);
    end else begin
      resume_level = low;
    end
  endfunction

  always_comb begin
    logic first_hit;
    logic second_hit;
    logic wake_evt;
    logic sleep_ok;
    logic modem_idle;
    first_hit = 1'b0;
    second_hit = 1'b0;
    wake_evt = 1'b0;
    sleep_ok = 1'b0;
    modem_idle = 1'b0;
    st_next = st_reg;
    st_next.push = 1'b0;

    if (char_wr_en) begin
      case (char_wr_sel)
        `USWFC_SEL_RESUME1: st_next.resume1 = char_wr_data;
        `USWFC_SEL_RESUME2: st_next.resume2 = char_wr_data;
        `USWFC_SEL_PAUSE1: st_next.pause1 = char_wr_data;
        default: st_next.pause2 = char_wr_data;
      endcase
    end

    // A character held back earlier is released one cycle later.
    if (st_reg.spill_valid) begin
      st_next.push = 1'b1;
      st_next.push_data = st_reg.spill_char;
      st_next.spill_valid = 1'b0;
    end

    // Receive path keeps running whatever the transmitter does.
    if (rx_char_valid) begin
      if (rx_flow_en && !rx_flow_double) begin
        if (hit[2]) begin
          first_hit = 1'b1;
          st_next.halt_req = 1'b1;
        end else if (hit[0]) begin
          second_hit = 1'b1;
          st_next.halt_req = 1'b0;
        end
      end else if (rx_flow_en) begin
        if (st_reg.held_valid) begin
          st_next.held_valid = 1'b0;
          if (st_reg.held_is_pause ? hit[3] : hit[1]) begin
            st_next.halt_req = st_reg.held_is_pause;
            first_hit = st_reg.held_is_pause;
            second_hit = !st_reg.held_is_pause;
          end else begin
            // Held character was ordinary data after all.
            st_next.push = 1'b1;
            st_next.push_data = st_reg.held_char;
            if (hit[2] || hit[0]) begin
              st_next.held_valid = 1'b1;
              st_next.held_is_pause = hit[2];
              st_next.held_char = rx_char_data;
            end else begin
              st_next.spill_valid = 1'b1;
              st_next.spill_char = rx_char_data;
            end
          end
        end else if (hit[2] || hit[0]) begin
          st_next.held_valid = 1'b1;
          st_next.held_is_pause = hit[2];
          st_next.held_char = rx_char_data;
        end
      end
      if (!first_hit && !second_hit && !st_next.held_valid &&
          !st_next.spill_valid && !st_next.push) begin
        st_next.push = 1'b1;
        st_next.push_data = rx_char_data;
      end else if (!first_hit && !second_hit && !st_next.held_valid &&
                   !st_next.spill_valid) begin
        st_next.spill_valid = 1'b1;
        st_next.spill_char = rx_char_data;
      end
    end

    // The flag clears on a resume or a status read; a new set wins.
    if (second_hit || isr_read) begin
      st_next.flow_flag = 1'b0;
    end
    if (first_hit && pause_int_en) begin
      st_next.flow_flag = 1'b1;
    end
    if (rx_char_valid && special_char_en && hit[3] && !first_hit &&
        !second_hit) begin
      st_next.flow_flag = 1'b1;
    end

    // Halt only at a character boundary.
    if (!st_next.halt_req) begin
      st_next.tx_halt = 1'b0;
    end else if (!tx_busy || tx_char_done) begin
      st_next.tx_halt = 1'b1;
    end

    // Automatic pause and resume sender.
    case (st_reg.send_state)
      SND_IDLE: begin
        if (tx_auto_en && !st_reg.pause_sent && rx_fifo_count >=
            pause_level(trig_table, trig_sel, trig_level)) begin
          st_next.send_state = SND_WAIT;
          st_next.wait_cnt = 2'h0;
          st_next.send_resume = 1'b0;
        end else if (st_reg.pause_sent && rx_fifo_count <
            resume_level(trig_table, trig_sel, trig_level, lower_level,
                         hysteresis)) begin
          st_next.send_state = SND_FIRST;
          st_next.send_resume = 1'b1;
        end
      end
      SND_WAIT: begin
        if (char_time_tick) begin
          st_next.wait_cnt = st_reg.wait_cnt + 2'h1;
        end
        if (st_next.wait_cnt == `USWFC_PAUSE_DELAY_CHARS) begin
          st_next.send_state = SND_FIRST;
        end
      end
      SND_FIRST: begin
        if (flow_tx_ack) begin
          st_next.send_state = tx_auto_double ? SND_SECOND : SND_IDLE;
          st_next.pause_sent = tx_auto_double ? st_reg.pause_sent :
                               !st_reg.send_resume;
        end
      end
      default: begin
        if (flow_tx_ack) begin
          st_next.send_state = SND_IDLE;
          st_next.pause_sent = !st_reg.send_resume;
        end
      end
    endcase
    st_next.tx_req = (st_next.send_state == SND_FIRST) ||
                     (st_next.send_state == SND_SECOND);
    if (st_next.send_state == SND_SECOND) begin
      st_next.tx_data = st_next.send_resume ? st_reg.resume2 : st_reg.pause2;
    end else begin
      st_next.tx_data = st_next.send_resume ? st_reg.resume1 : st_reg.pause1;
    end

    // Sleep control. Isolated hosts cannot wake the part by writing.
    st_next.rxd_last = rxd_in;
    wake_evt = (rxd_in && !st_reg.rxd_last) || (|modem_status_delta) ||
               (thr_write && !st_reg.isolate);
    sleep_ok = !st_reg.irq && !other_int_pending && !st_reg.wake_int &&
               (divisor != 16'h0000) && sleep_en &&
               (modem_status_delta == 4'h0) && !rxd_in;
    if (isr_read) begin
      st_next.wake_int = 1'b0;
    end
    if (st_reg.asleep && wake_evt) begin
      st_next.asleep = 1'b0;
      st_next.wake_int = sleep_en;
    end else if (!st_reg.asleep && sleep_ok && !wake_evt) begin
      st_next.asleep = 1'b1;
    end

    // Idle timer for the charge pump while the UART is awake.
    modem_idle = (modem_status_delta == 4'h0) && !rxd_in && !tx_busy &&
                 !thr_write;
    if (!charge_pump_autosleep_pin || !modem_idle || st_reg.asleep) begin
      st_next.idle_cnt = 31'h00000000;
    end else if (st_reg.idle_cnt != IDLE_CYCLES) begin
      st_next.idle_cnt = st_reg.idle_cnt + 31'h00000001;
    end
    // The pump restarts as soon as the pin drops, or the oscillator runs with the idle timer short of IDLE_CYCLES.
    st_next.pump_on = !charge_pump_autosleep_pin ||
                      !(st_next.asleep ||
                        st_next.idle_cnt == IDLE_CYCLES);
    st_next.isolate = isolate_pin && st_next.asleep;
    st_next.irq = st_next.flow_flag || st_next.wake_int;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.send_state <= SND_IDLE;
      st_reg.pump_on <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rx_fifo_push = st_reg.push;
  assign rx_fifo_data = st_reg.push_data;
  assign tx_halt = st_reg.tx_halt;
  assign flow_tx_req = st_reg.tx_req;
  assign flow_tx_data = st_reg.tx_data;
  assign flow_flag = st_reg.flow_flag;
  assign wake_int = st_reg.wake_int;
  assign irq = st_reg.irq;
  assign osc_run = !st_reg.asleep;
  assign charge_pump_on = st_reg.pump_on;
  assign host_isolate = st_reg.isolate;
endmodule // uswfc_ctrl

/* File: pkg/uswfc_map.svh */
// Constants of the software flow control and sleep controller.
`ifndef USWFC_MAP_SVH
`define USWFC_MAP_SVH
`define USWFC_CLK_HZ 64'd50000000
`define USWFC_IDLE_SECONDS 64'd30
`define USWFC_IDLE_CYCLES (`USWFC_IDLE_SECONDS * `USWFC_CLK_HZ)
`define USWFC_PAUSE_DELAY_CHARS 2'h2
`define USWFC_SEL_RESUME1 2'h0
`define USWFC_SEL_RESUME2 2'h1
`define USWFC_SEL_PAUSE1 2'h2
`define USWFC_SEL_PAUSE2 2'h3
`define USWFC_TABLE_A 2'h0
`define USWFC_TABLE_B 2'h1
`define USWFC_TABLE_C 2'h2
`define USWFC_TABLE_D 2'h3
`define USWFC_TB_LVL0 7'h08
`define USWFC_TB_LVL1 7'h10
`define USWFC_TB_LVL2 7'h18
`define USWFC_TB_LVL3 7'h1C
`define USWFC_TB_RES0 7'h00
`define USWFC_TB_RES1 7'h08
`define USWFC_TB_RES2 7'h10
`define USWFC_TB_RES3 7'h18
`define USWFC_ISR_WAKE 4'h1
`define USWFC_ISR_NONE 4'h1
`define USWFC_ISR_FLOW 4'h0
`define USWFC_ISR_FLOW_BIT 4
`endif

/* File: pkg/uswfc_pkg.sv */
// Types of the software flow control and sleep controller.
package uswfc_pkg;
  typedef enum logic [1:0] {
    SND_IDLE,
    SND_WAIT,
    SND_FIRST,
    SND_SECOND
  } uswfc_send_type;

  typedef struct packed {
    logic [7:0] resume1;
    logic [7:0] resume2;
    logic [7:0] pause1;
    logic [7:0] pause2;
    logic held_valid;
    logic held_is_pause;
    logic [7:0] held_char;
    logic spill_valid;
    logic [7:0] spill_char;
    logic halt_req;
    logic tx_halt;
    logic flow_flag;
    logic push;
    logic [7:0] push_data;
    uswfc_send_type send_state;
    logic send_resume;
    logic pause_sent;
    logic [1:0] wait_cnt;
    logic tx_req;
    logic [7:0] tx_data;
    logic asleep;
    logic wake_int;
    logic rxd_last;
    logic [30:0] idle_cnt;
    logic pump_on;
    logic isolate;
    logic irq;
  } uswfc_state_type;
endpackage

/* File: design/uswfc_char_match.sv */
// Word-length masked compare of a received character with four characters.
`timescale 1ns/1ps
module uswfc_char_match
  import uswfc_pkg::*;
(
  // Word length select, 0 gives 5 bits up to 3 giving 8 bits.
  input wire logic [1:0] word_len_sel,
  // Character under test.
  input wire logic [7:0] rx_char,
  // Programmed characters.
  input wire logic [7:0] resume_char1,
  input wire logic [7:0] resume_char2,
  input wire logic [7:0] pause_char1,
  input wire logic [7:0] pause_char2,
  // Match results, bit order resume1, resume2, pause1, pause2.
  output logic [3:0] match
);
  // Bit 0 of each character lines up with the first received data bit.
  function automatic logic same(input logic [1:0] wl, input logic [7:0] a,
                                input logic [7:0] b);
    logic [7:0] mask;
    mask = 8'hFF >> (3'h3 - {1'b0, wl});
    same = ((a ^ b) & mask) == 8'h00;
  endfunction

  always_comb begin
    match[0] = same(word_len_sel, rx_char, resume_char1);
    match[1] = same(word_len_sel, rx_char, resume_char2);
    match[2] = same(word_len_sel, rx_char, pause_char1);
    match[3] = same(word_len_sel, rx_char, pause_char2);
  end
endmodule // uswfc_char_match

/* File: test/uswfc_ctrl_sva.sv */
// Port assertions for the flow control and sleep controller.
`timescale 1ns/1ps
module uswfc_ctrl_sva (
  // Clock, reset and flow characters.
  input wire logic core_clk,
  input wire logic rst,
  input wire logic char_wr_en,
  input wire logic [1:0] char_wr_sel,
  input wire logic [7:0] char_wr_data,
  // Configuration.
  input wire logic rx_flow_en,
  input wire logic rx_flow_double,
  input wire logic [1:0] word_len_sel,
  input wire logic pause_int_en,
  input wire logic sleep_en,
  input wire logic [15:0] divisor,
  // Receive and transmit.
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rxd_in,
  input wire logic rx_fifo_push,
  input wire logic [7:0] rx_fifo_data,
  input wire logic tx_busy,
  input wire logic tx_char_done,
  input wire logic flow_tx_ack,
  input wire logic thr_write,
  input wire logic tx_halt,
  input wire logic flow_tx_req,
  input wire logic [7:0] flow_tx_data,
  // Interrupts and power.
  input wire logic other_int_pending,
  input wire logic [3:0] modem_status_delta,
  input wire logic flow_flag,
  input wire logic wake_int,
  input wire logic irq,
  input wire logic charge_pump_autosleep_pin,
  input wire logic osc_run,
  input wire logic charge_pump_on
);
  logic [7:0] p1_reg, r1_reg, mask;
  logic pz, rz, go;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      p1_reg <= 8'h00;
      r1_reg <= 8'h00;
    end else if (char_wr_en && char_wr_sel == 2'h2) begin
      p1_reg <= char_wr_data;
    end else if (char_wr_en && char_wr_sel == 2'h0) begin
      r1_reg <= char_wr_data;
    end
  end
  // Only the programmed word length takes part in a compare.
  assign mask = 8'hFF >> (2'h3 - word_len_sel);
  assign rz = rx_char_valid && rx_flow_en && !rx_flow_double
    && ((rx_char_data ^ r1_reg) & mask) == 8'h00;
  assign pz = rx_char_valid && rx_flow_en && !rx_flow_double && !rz
    && ((rx_char_data ^ p1_reg) & mask) == 8'h00;
  assign go = !irq && !other_int_pending && !wake_int && divisor != 16'h0000
    && sleep_en && modem_status_delta == 4'h0 && !rxd_in && !thr_write;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_pause_halt: assert property (
    pz && !tx_busy && pause_int_en |=> tx_halt && flow_flag && irq)
    else $error("pause char did not halt and flag");
  a_busy_wait: assert property (
    pz && tx_busy && !tx_char_done && !tx_halt |=> !tx_halt)
    else $error("halt cut into a busy character");
  a_flow_drop: assert property (
    pz || rz |=> !rx_fifo_push)
    else $error("flow char reached the fifo");
  a_plain_push: assert property (
    rx_char_valid && !rx_flow_en |=>
      rx_fifo_push && rx_fifo_data == $past(rx_char_data))
    else $error("received char not pushed");
  a_sleep_entry: assert property (
    osc_run && go |=> !osc_run)
    else $error("sleep not entered");
  a_sleep_block: assert property (
    osc_run && !go |=> osc_run)
    else $error("sleep entered while blocked");
  a_wake_report: assert property (
    !osc_run && modem_status_delta != 4'h0 |=>
      osc_run && wake_int == $past(sleep_en))
    else $error("modem change did not wake");
  a_pump_pin: assert property (
    !charge_pump_autosleep_pin |=> charge_pump_on)
    else $error("charge pump off with pin low");
  a_req_hold: assert property (
    flow_tx_req && !flow_tx_ack |=> flow_tx_req && $stable(flow_tx_data))
    else $error("flow request dropped before ack");
endmodule // uswfc_ctrl_sva

bind uswfc_ctrl uswfc_ctrl_sva u_sva (.*);

/* File: test/uswfc_remote.sv */
// Remote UART model: sends characters and takes flow characters.
`timescale 1ns/1ps
module uswfc_remote (
  // Clock.
  input wire logic core_clk,
  // Flow characters from the controller.
  input wire logic flow_tx_req,
  input wire logic [7:0] flow_tx_data,
  output logic flow_tx_ack,
  // Character timing and received characters.
  output logic char_time_tick,
  output logic rx_char_valid,
  output logic [7:0] rx_char_data
);
  int ack_wait = 0;
  int tick_cnt = 0;
  logic [7:0] got[$];
  initial begin
    {flow_tx_ack, char_time_tick, rx_char_valid} = 3'h0;
    rx_char_data = 8'h00;
  end
  // One character time is eight clocks, far shorter than a real baud.
  always @(posedge core_clk) begin
    tick_cnt = (tick_cnt + 1) % 8;
    #1 char_time_tick = (tick_cnt == 0);
  end
  always begin
    @(posedge core_clk);
    if (flow_tx_req === 1'b1) begin
      repeat (ack_wait) @(posedge core_clk);
      #1 flow_tx_ack = 1'b1;
      got.push_back(flow_tx_data);
      @(posedge core_clk);
      #1 flow_tx_ack = 1'b0;
    end
  end
  // The data lines show the inverse once a character has been handed over.
  task automatic send(input logic [7:0] c);
    rx_char_valid = 1'b1;
    rx_char_data = c;
    @(posedge core_clk);
    #1 rx_char_valid = 1'b0;
    rx_char_data = ~c;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
endmodule // uswfc_remote

/* File: test/testbench.sv */
// Self-checking bench for the flow control and sleep controller.
`timescale 1ns/1ps
module testbench;
  logic core_clk, rst, char_wr_en, rx_flow_en, rx_flow_double, tx_auto_en;
  logic tx_auto_double, special_char_en, pause_int_en, sleep_en, rxd_in;
  logic tx_busy, tx_char_done, thr_write, other_int_pending, isr_read;
  logic charge_pump_autosleep_pin, isolate_pin, rx_char_valid, tx_halt;
  logic char_time_tick, flow_tx_ack, rx_fifo_push, flow_tx_req, flow_flag;
  logic wake_int, irq, osc_run, charge_pump_on, host_isolate;
  logic [1:0] char_wr_sel, word_len_sel, trig_table, trig_sel;
  logic [7:0] char_wr_data, rx_char_data, rx_fifo_data, flow_tx_data, r;
  logic [15:0] divisor;
  logic [6:0] trig_level, lower_level, hysteresis, rx_fifo_count, p, f;
  logic [3:0] modem_status_delta;
  logic [7:0] pushed[$];
  logic [31:0] seed = 32'h00000058;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  uswfc_ctrl #(.IDLE_CYCLES(31'h00000014)) dut (.*);
  uswfc_remote u_rem (.*);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (rx_fifo_push === 1'b1) pushed.push_back(rx_fifo_data);
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [6:0] pause_at(input int i);
    return (i == 3) ? 7'h1C : 7'(8 * i + 8);
  endfunction
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic tap(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    char_wr_en = 1'b1;
    char_wr_sel = s;
    char_wr_data = d;
    step(1);
  endtask
  task automatic flow_pass(input logic [6:0] lv, fire, input logic dbl);
    int n = 0;
    tx_auto_double = dbl;
    rx_fifo_count = lv - 7'h01;
    step(40);
    chk("early pause", 8'h00, 8'(u_rem.got.size()));
    rx_fifo_count = lv;
    while (flow_tx_req !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    chk("pause delay", 8'h01, 8'(n >= 8 && n <= 18));
    step(20);
    chk("pause char", 8'h13, u_rem.got.pop_front());
    if (dbl) chk("pause char", 8'h14, u_rem.got.pop_front());
    rx_fifo_count = fire + 7'h01;
    step(30);
    chk("early resume", 8'h00, 8'(u_rem.got.size()));
    rx_fifo_count = fire;
    step(30);
    chk("resume char", 8'h11, u_rem.got.pop_front());
    if (dbl) chk("resume char", 8'h12, u_rem.got.pop_front());
  endtask
  task automatic results();
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {char_wr_en, rx_flow_en, rx_flow_double, tx_auto_en, tx_auto_double,
     special_char_en, pause_int_en, sleep_en, rxd_in, tx_busy, tx_char_done,
     thr_write, other_int_pending, isr_read, charge_pump_autosleep_pin,
     isolate_pin, char_wr_sel, char_wr_data, divisor, trig_table, trig_sel,
     trig_level, lower_level, hysteresis, rx_fifo_count,
     modem_status_delta} = '0;
    rst = 1'b1;
    word_len_sel = 2'h3;
    step(5);
    rst = 1'b0;
    chk("osc_run", 8'h01, 8'(osc_run));
    rx_flow_en = 1'b1;
    u_rem.send(8'h00);
    chk("pushes", 8'h00, 8'(pushed.size()));
    chk("halt", 8'h01, 8'(tx_halt));
    for (int i = 0; i < 4; i++) wr(2'(i), 8'(8'h11 + i));
    char_wr_en = 1'b0;
    u_rem.send(8'h11);
    chk("halt", 8'h00, 8'(tx_halt));
    tx_busy = 1'b1;
    pause_int_en = 1'b1;
    u_rem.send(8'h13);
    chk("halt", 8'h00, 8'(tx_halt));
    tap(tx_char_done);
    tx_busy = 1'b0;
    chk("halt", 8'h01, 8'(tx_halt));
    chk("irq", 8'h01, 8'(irq));
    for (int i = 0; i < 5; i++) begin
      tx_busy = 1'(rnd());
      r = 8'(32'h40 | (rnd() & 32'h3F));
      u_rem.send(r);
      chk("push", r, pushed.pop_front());
    end
    tx_busy = 1'b0;
    u_rem.send(8'h11);
    chk("halt", 8'h00, 8'(tx_halt));
    chk("flag", 8'h00, 8'(flow_flag));
    for (int w = 0; w < 4; w++) begin
      word_len_sel = 2'(w);
      r = 8'hFF << (5 + w);
      u_rem.send(8'h13 ^ r);
      chk("halt", 8'h01, 8'(tx_halt));
      u_rem.send(8'h13 ^ (8'h10 << w));
      chk("push", 8'h13 ^ (8'h10 << w), pushed.pop_front());
      u_rem.send(8'h11 ^ r);
      chk("halt", 8'h00, 8'(tx_halt));
    end
    rx_flow_double = 1'b1;
    u_rem.send(8'h13);
    u_rem.send(8'h14);
    chk("halt", 8'h01, 8'(tx_halt));
    u_rem.send(8'h11);
    u_rem.send(8'h12);
    chk("halt", 8'h00, 8'(tx_halt));
    chk("pushes", 8'h00, 8'(pushed.size()));
    u_rem.send(8'h13);
    u_rem.send(8'h55);
    chk("push", 8'h13, pushed.pop_front());
    chk("push", 8'h55, pushed.pop_front());
    {rx_flow_double, rx_flow_en, special_char_en} = 3'h1;
    tap(isr_read);
    u_rem.send(8'h14);
    chk("push", 8'h14, pushed.pop_front());
    chk("flag", 8'h01, 8'(flow_flag));
    tx_auto_en = 1'b1;
    for (int k = 0; k < 7; k++) begin
      u_rem.ack_wait = k % 3;
      trig_level = 7'h20 | 7'(rnd() & 32'h1F);
      lower_level = 7'h08 | 7'(rnd() & 32'h0F);
      hysteresis = 7'h01 | 7'(rnd() & 32'h0F);
      trig_table = (k < 4) ? 2'h1 : (k == 4) ? 2'h0 : (k == 5) ? 2'h2 : 2'h3;
      trig_sel = 2'(k);
      p = (k < 4) ? pause_at(k) : trig_level;
      f = (k == 0) ? 7'h00 : (k < 4) ? pause_at(k - 1) :
          (k == 6) ? trig_level - hysteresis - 7'h01 : lower_level - 7'h01;
      flow_pass(p, f, k[0]);
    end
    tap(isr_read);
    for (int b = 0; b < 4; b++) begin
      divisor = (b == 0) ? 16'h0000 : (16'h0001 | 16'(rnd()));
      other_int_pending = (b == 1);
      modem_status_delta = (b == 2) ? 4'h8 : 4'h0;
      rxd_in = (b == 3);
      sleep_en = 1'b1;
      step(5);
      chk("osc_run", 8'h01, 8'(osc_run));
      sleep_en = 1'b0;
    end
    {other_int_pending, rxd_in, modem_status_delta} = 6'h00;
    sleep_en = 1'b1;
    step(3);
    chk("osc_run", 8'h00, 8'(osc_run));
    chk("pump", 8'h01, 8'(charge_pump_on));
    charge_pump_autosleep_pin = 1'b1;
    isolate_pin = 1'b1;
    step(2);
    chk("pump", 8'h00, 8'(charge_pump_on));
    chk("isolate", 8'h01, 8'(host_isolate));
    tap(thr_write);
    step(2);
    chk("osc_run", 8'h00, 8'(osc_run));
    modem_status_delta = 4'h2;
    step(2);
    chk("wake_int", 8'h01, 8'(wake_int));
    chk("pump", 8'h01, 8'(charge_pump_on));
    modem_status_delta = 4'h0;
    step(5);
    chk("osc_run", 8'h01, 8'(osc_run));
    tap(isr_read);
    step(4);
    chk("wake_int", 8'h00, 8'(wake_int));
    chk("osc_run", 8'h00, 8'(osc_run));
    rxd_in = 1'b1;
    step(2);
    chk("osc_run", 8'h01, 8'(osc_run));
    {rxd_in, isolate_pin} = 2'h0;
    tap(isr_read);
    step(4);
    tap(thr_write);
    step(1);
    chk("osc_run", 8'h01, 8'(osc_run));
    sleep_en = 1'b0;
    tap(isr_read);
    step(40);
    chk("osc_run", 8'h01, 8'(osc_run));
    chk("pump", 8'h00, 8'(charge_pump_on));
    charge_pump_autosleep_pin = 1'b0;
    step(2);
    chk("pump", 8'h01, 8'(charge_pump_on));
    results();
  end
endmodule // testbench
